// ### include/tcpwm_pkg.sv
// Package with constants and carrier types for the timer/counter/PWM unit
package tcpwm_pkg;

	// ==========================================================
	// Sizes
	localparam int CNT_WIDTH   = 16;   // Counter width
	localparam int NUM_UNITS   = 5;    // Independent instances
	localparam int DEAD_WIDTH  = 8;    // Dead-band count width

	// ==========================================================
	// Reset values
	localparam logic [15:0] PERIOD_RST  = 16'hFFFF;
	localparam logic [15:0] COMPARE_RST = 16'h0000;
	localparam logic [15:0] COUNT_RST   = 16'h0000;
	localparam logic [15:0] CAPTURE_RST = 16'h0000;
	localparam logic [7:0]  DEAD_RST    = 8'h00;

	// ==========================================================
	// Counter states
	typedef enum logic [1:0] {
		TCPWM_IDLE    = 2'b00,
		TCPWM_RUN     = 2'b01,
		TCPWM_STOPPED = 2'b10
	} tcpwm_state_type;

	// Configuration of one unit
	typedef struct packed {
		logic        enable;     // Counter runs while high
		logic        oneShot;    // Halt on period match instead of reload
		logic [15:0] period;     // Period value
		logic [15:0] compare;    // Compare value for duty cycle
		logic [7:0]  deadTime;   // Dead band in clock cycles
		logic        killLevel;  // Forced level of true output under kill
		logic        killLevelN; // Forced level of complementary output
	} tcpwm_cfg_type;

	// Status of one unit
	typedef struct packed {
		logic [15:0] count;      // Current count
		logic [15:0] capture;    // Captured count
		logic        running;    // Counter active
		logic        capEvent;   // One-cycle pulse on capture
		logic        tcEvent;    // One-cycle pulse on period match
	} tcpwm_stat_type;

endpackage

// ### rtl/tcpwm_channel.sv
// One timer/counter/PWM channel: counter, capture, compare, dead band, kill
`timescale 1ns/10ps
module tcpwm_channel #(
	parameter int CW = 16,
	parameter int DW = 8
) (
	// Clock and reset
	input  wire logic                    core_clk,
	input  wire logic                    rst_n,
	// Configuration and events (already synchronised)
	input  wire tcpwm_pkg::tcpwm_cfg_type cfg,
	input  wire logic                    capIn,
	input  wire logic                    killIn,
	// Results
	output wire tcpwm_pkg::tcpwm_stat_type stat,
	output logic                         pwmOut,
	output logic                         pwmOutN
);

	// ==========================================================
	// Elaboration checks
	// Count and dead-band registers are built for the package widths only
	if (CW != tcpwm_pkg::CNT_WIDTH) begin : gBadCw
		$error("Counter width must be 16");
	end
	if (DW != tcpwm_pkg::DEAD_WIDTH) begin : gBadDw
		$error("Dead width must be 8");
	end

	// ==========================================================
	// State
	tcpwm_pkg::tcpwm_state_type stateQ, stateD;   // Counter state
	logic [15:0]                countQ, countD;   // Counter
	logic [15:0]                capQ, capD;       // Capture register
	logic                       capPrevQ, capPrevD; // Capture edge memory
	logic                       capEvQ, capEvD;   // Capture pulse
	logic                       tcEvQ, tcEvD;     // Period match pulse
	logic                       rawQ, rawD;       // Compare result
	logic [7:0]                 dtQ, dtD;         // Dead-band counter
	logic                       outQ, outD;       // True output
	logic                       outNQ, outND;     // Complementary output
	logic                       runQ, runD;       // Running flag

	// ==========================================================
	// Next-state logic
	always_comb begin
		stateD   = stateQ;
		countD   = countQ;
		capD     = capQ;
		capPrevD = capIn;
		capEvD   = 1'b0;
		tcEvD    = 1'b0;
		rawD     = rawQ;
		dtD      = dtQ;
		outD     = outQ;
		outND    = outNQ;
		// Counter sequence
		unique case (stateQ)
			tcpwm_pkg::TCPWM_IDLE: begin
				countD = tcpwm_pkg::COUNT_RST;
				if (cfg.enable) stateD = tcpwm_pkg::TCPWM_RUN;
			end
			tcpwm_pkg::TCPWM_RUN: begin
				if (!cfg.enable) begin
					stateD = tcpwm_pkg::TCPWM_IDLE;
				end else if (countQ == cfg.period) begin
					tcEvD = 1'b1;
					if (cfg.oneShot) begin
						stateD = tcpwm_pkg::TCPWM_STOPPED;
					end else begin
						countD = tcpwm_pkg::COUNT_RST;
					end
				end else begin
					countD = countQ + 16'h0001;
				end
			end
			tcpwm_pkg::TCPWM_STOPPED: begin
				// Holds count until software drops enable
				if (!cfg.enable) stateD = tcpwm_pkg::TCPWM_IDLE;
			end
			default: stateD = tcpwm_pkg::TCPWM_IDLE;
		endcase
		// Capture on rising edge of the event
		if (capIn && !capPrevQ) begin
			capD   = countQ;
			capEvD = 1'b1;
		end
		// Running flag registered so the status bit leaves a flip-flop
		runD = (stateD == tcpwm_pkg::TCPWM_RUN);
		// Compare produces the duty cycle
		rawD = (stateQ != tcpwm_pkg::TCPWM_IDLE) && (countQ < cfg.compare);
		// Dead band: delay each rising edge, fall at once
		if (rawD != rawQ) begin
			dtD = cfg.deadTime;
		end else if (dtQ != 8'h00) begin
			dtD = dtQ - 8'h01;
		end
		if (killIn) begin
			outD  = cfg.killLevel;
			outND = cfg.killLevelN;
		end else begin
			outD  = rawQ && (dtQ == 8'h00) && (rawD == rawQ);
			outND = !rawQ && (dtQ == 8'h00) && (rawD == rawQ);
		end
	end

	// ==========================================================
	// Registers
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			stateQ   <= tcpwm_pkg::TCPWM_IDLE;
			countQ   <= tcpwm_pkg::COUNT_RST;
			capQ     <= tcpwm_pkg::CAPTURE_RST;
			capPrevQ <= 1'b0;
			capEvQ   <= 1'b0;
			tcEvQ    <= 1'b0;
			rawQ     <= 1'b0;
			dtQ      <= tcpwm_pkg::DEAD_RST;
			outQ     <= 1'b0;
			outNQ    <= 1'b0;
			runQ     <= 1'b0;
		end else begin
			stateQ   <= stateD;
			countQ   <= countD;
			capQ     <= capD;
			capPrevQ <= capPrevD;
			capEvQ   <= capEvD;
			tcEvQ    <= tcEvD;
			rawQ     <= rawD;
			dtQ      <= dtD;
			outQ     <= outD;
			outNQ    <= outND;
			runQ     <= runD;
		end
	end

	// ==========================================================
	// Outputs
	assign stat.count    = countQ;
	assign stat.capture  = capQ;
	assign stat.running  = runQ;
	assign stat.capEvent = capEvQ;
	assign stat.tcEvent  = tcEvQ;
	assign pwmOut        = outQ;
	assign pwmOutN       = outNQ;

endmodule

// ### rtl/tcpwm_top.sv
// Top level: five timer/counter/PWM channels with pin synchronisers
//
// Functional notes
// - Sixteen-bit counter with programmable period
// - Capture event latches count into capture
// - Period match halts or reloads counter
// - Compare against value gives PWM duty
// - True and complementary outputs with dead band
// - Kill forces outputs in hardware, three clock cycles after the pin
// - Five independent channels, own resources each
`timescale 1ns/10ps
module tcpwm_top #(
	parameter int NUNITS = 5,
	parameter int CW     = 16,
	parameter int DW     = 8
) (
	// Clock and reset
	input  wire logic                                 core_clk,
	input  wire logic                                 rst_n,
	// Per-channel configuration (same clock domain)
	input  wire tcpwm_pkg::tcpwm_cfg_type [NUNITS-1:0] cfgIn,
	// Pins from outside
	input  wire logic [NUNITS-1:0]                    capPin,
	input  wire logic [NUNITS-1:0]                    killPin,
	// Status back to software
	output wire tcpwm_pkg::tcpwm_stat_type [NUNITS-1:0] statOut,
	// PWM pins
	output wire logic [NUNITS-1:0]                    pwmLine,
	output wire logic [NUNITS-1:0]                    pwmLineN
);

	// ==========================================================
	// Elaboration checks
	// Pin and channel wiring assume the package unit count
	if (NUNITS != tcpwm_pkg::NUM_UNITS) begin : gBadUnits
		$error("Unit count must be five");
	end

	// ==========================================================
	// Two-stage synchronisers for pin inputs
	logic [NUNITS-1:0] capS1Q, capS2Q;   // Capture pin stages
	logic [NUNITS-1:0] killS1Q, killS2Q; // Kill pin stages

	// Register the pin stages
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			capS1Q  <= '0;
			capS2Q  <= '0;
			killS1Q <= '0;
			killS2Q <= '0;
		end else begin
			capS1Q  <= capPin;
			capS2Q  <= capS1Q;
			killS1Q <= killPin;
			killS2Q <= killS1Q;
		end
	end

	// ==========================================================
	// Channels
	genvar i;
	generate
		for (i = 0; i < NUNITS; i = i + 1) begin : gUnit
			tcpwm_channel #(.CW(CW), .DW(DW)) uChan (
				.core_clk (core_clk),
				.rst_n    (rst_n),
				.cfg      (cfgIn[i]),
				.capIn    (capS2Q[i]),
				.killIn   (killS2Q[i]),
				.stat     (statOut[i]),
				.pwmOut   (pwmLine[i]),
				.pwmOutN  (pwmLineN[i])
			);
		end
	endgenerate

endmodule

// ### tb/tcpwm_props.sv
// Checker for the five-channel timer/counter/PWM top level
`timescale 1ns/10ps
module tcpwm_props #(parameter int NUNITS = 5, CW = 16, DW = 8) (
	// Clock and reset
	input wire logic                                  core_clk,
	input wire logic                                  rst_n,
	// Inputs of the design
	input wire tcpwm_pkg::tcpwm_cfg_type [NUNITS-1:0] cfgIn,
	input wire logic [NUNITS-1:0]                     capPin,
	input wire logic [NUNITS-1:0]                     killPin,
	// Outputs of the design
	input wire tcpwm_pkg::tcpwm_stat_type [NUNITS-1:0] statOut,
	input wire logic [NUNITS-1:0]                     pwmLine,
	input wire logic [NUNITS-1:0]                     pwmLineN
);
	// Channel zero stands for all five
	wire tcpwm_pkg::tcpwm_cfg_type c = cfgIn[0];
	wire tcpwm_pkg::tcpwm_stat_type s = statOut[0];
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rst_n);
	a_count_step: assert property (c.enable && s.running && s.count != c.period
		|=> s.count == $past(s.count) + 16'h1) else $error("count step");
	a_tc_reload: assert property (c.enable && !c.oneShot && s.running && s.count == c.period
		|=> s.count == 16'h0 && s.tcEvent) else $error("reload");
	a_tc_halt: assert property (c.enable && c.oneShot && s.running && s.count == c.period
		|=> !s.running && $stable(s.count)) else $error("halt");
	a_idle_zero: assert property (!c.enable [*2] |=> s.count == 16'h0 && !s.running)
		else $error("idle");
	a_cap_hold: assert property (!s.capEvent |-> $stable(s.capture)) else $error("cap");
	a_cap_bound: assert property ($rose(capPin[0]) |-> ##[1:5] s.capEvent)
		else $error("cap late");
	a_kill_force: assert property (killPin[0] [*3] |=> pwmLine[0] == c.killLevel
		&& pwmLineN[0] == c.killLevelN) else $error("kill");
	a_dead_gap: assert property (pwmLine[0] |-> !pwmLineN[0]) else $error("overlap");
endmodule
bind tcpwm_top tcpwm_props #(.NUNITS(NUNITS), .CW(CW), .DW(DW)) i_tcpwm_props (.core_clk,
	.rst_n, .cfgIn, .capPin, .killPin, .statOut, .pwmLine, .pwmLineN);

// ### tb/tcpwm_stage.sv
// Power-stage model: counts cycles with both switches of a leg on
`timescale 1ns/10ps
module tcpwm_stage (
	// Gate drives
	input wire logic       core_clk,
	input wire logic [4:0] hi,
	input wire logic [4:0] lo,
	// Shoot-through count
	output int             shoot
);
	int hits = 0; // Cycles with both switches on
	// Both switches on shorts the supply
	always @(posedge core_clk) if ((hi & lo) != 5'h00) hits++;
	assign shoot = hits;
endmodule

// ### tb/test_timer_counter_pwm_unit.sv
// Self-checking bench for the five-channel timer/counter/PWM unit
`timescale 1ns/10ps
`define CHK(a, b) begin checksDone++; if ((a) !== (b)) begin errorCnt++; \
	$display("Error at %0t: %h vs %h", $time, a, b); end end
module test_timer_counter_pwm_unit;
	logic                           core_clk, rst_n, kw;
	tcpwm_pkg::tcpwm_cfg_type [4:0]  cfgIn;
	logic [4:0]                     capPin, killPin, pwmLine, pwmLineN;
	tcpwm_pkg::tcpwm_stat_type [4:0] statOut;
	int                             errorCnt, checksDone, shoot, seed, st[5], cnt[5], pc[5];
	int                             sc[5];
	bit                             rw;
	bit [4:0]                       rq, k1, k2;
	logic [4:0]                     eo, en;
	tcpwm_top i_tcpwm_top (.core_clk, .rst_n, .cfgIn, .capPin, .killPin, .statOut, .pwmLine,
		.pwmLineN);
	tcpwm_stage i_tcpwm_stage (.core_clk, .hi(pwmLine), .lo(pwmLineN), .shoot);
	task close_out;
		$display("Errors %0d, checks %0d", errorCnt, checksDone);
		if (errorCnt == 0 && checksDone > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask
	initial begin
		core_clk = 0;
		forever #50 core_clk = ~core_clk;
	end
	// Reference counters, per channel, on the design's edge
	always @(posedge core_clk) for (int i = 0; i < 5; i++) begin
		pc[i] = cnt[i];
		rw = (st[i] != 0) && (cnt[i] < cfgIn[i].compare);
		if (!rst_n) begin
			st[i] = 0;
			cnt[i] = 0;
			k1[i] = 1'b0;
			k2[i] = 1'b0;
			rq[i] = 1'b0;
			sc[i] = 300;
			{eo[i], en[i]} = 2'b00;
		end else begin
			// Cycles since the duty level last changed
			sc[i] = (rw != rq[i]) ? 0 : ((sc[i] < 300) ? sc[i] + 1 : 300);
			rq[i] = rw;
			// Kill two synchroniser stages late, then dead band, then duty
			if (k2[i]) {eo[i], en[i]} = {cfgIn[i].killLevel, cfgIn[i].killLevelN};
			else if (sc[i] > cfgIn[i].deadTime) {eo[i], en[i]} = {rw, !rw};
			else {eo[i], en[i]} = 2'b00;
			k2[i] = k1[i];
			k1[i] = killPin[i];
			// Counter: idle clears, dropping enable leaves one cycle later
			if (st[i] == 0) begin
				cnt[i] = 0;
				st[i] = cfgIn[i].enable;
			end else if (!cfgIn[i].enable) st[i] = 0;
			else if (st[i] == 1) begin
				if (cnt[i] != cfgIn[i].period) cnt[i]++;
				else if (cfgIn[i].oneShot) st[i] = 2;
				else cnt[i] = 0;
			end
		end
	end
	// Compare every channel each cycle
	always @(negedge core_clk) if (rst_n) begin
		`CHK(pwmLine, eo)
		`CHK(pwmLineN, en)
		for (int i = 0; i < 5; i++) begin
			`CHK(statOut[i].count, 16'(cnt[i]))
			`CHK(statOut[i].running, st[i] == 1)
			if (statOut[i].capEvent) `CHK(statOut[i].capture, 16'(pc[i]))
			if (!kw && i == 3) `CHK(pwmLine[3], 1'b0)
		end
	end
	// Watchdog
	initial begin
		#100000;
		errorCnt++;
		close_out;
	end
	initial begin
		{seed, kw, rst_n, capPin, killPin} = {32'd13207, 1'b1, 1'b0, 10'h000};
		for (int i = 0; i < 5; i++) cfgIn[i] = '{1'b0, i == 4, 16'(4 + $unsigned($random(seed))
			% 12), (i == 3) ? 16'h0000 : 16'h0003 + 16'(2 * i), 8'h02, 1'b1, 1'b0};
		repeat (12) @(negedge core_clk);
		{rst_n, kw} = 2'b10;
		for (int r = 0; r < 2; r++) begin
			// Second round starts from a reset with every channel disabled
			if (r == 1) begin
				rst_n = 1'b0;
				repeat (3) @(negedge core_clk);
				rst_n = 1'b1;
			end
			for (int i = 0; i < 5; i++) cfgIn[i].enable = 1'b1;
			repeat (40) begin
				@(negedge core_clk);
				capPin = 5'($random(seed));
			end
			{kw, killPin} = {1'b1, 5'h1F};
			repeat (6) @(negedge core_clk);
			`CHK(pwmLine, 5'h1F)
			`CHK(pwmLineN, 5'h00)
			killPin = 5'h00;
			repeat (8) @(negedge core_clk);
			kw = 0;
			for (int i = 0; i < 5; i++) cfgIn[i].enable = 1'b0;
			repeat (3) @(negedge core_clk);
		end
		`CHK(shoot, 0)
		close_out;
	end
endmodule
